// >>> design/iwd_pkg.sv
// constants and types for the instruction word decoder and timing block
// Contract
// - each instruction is one 14-bit word holding opcode and all operands
// - opcodes sort into byte-oriented, bit-oriented and literal/control classes
// - every instruction takes one instruction cycle unless listed below
// - both subroutine invocation forms take two instruction cycles
// - subroutine return, return with literal and interrupt exit take two cycles
// - jumps cost two cycles; bit-test skips and step-and-skip instructions cost two only when they skip
// - indirect access while pointer addresses program memory adds one cycle
// - one instruction cycle is four oscillator clocks
// - file register instructions read, modify, then store; read always happens
// - destination bit 0 writes accumulator, 1 writes the file register
// - register address selects file register 0x00 to 0x7F in current bank
// - bit number selects one bit of the 8-bit file register
// - don't-care opcode bits never change decoding
// - pointer number selects indirect pointer or access port 0 or 1
// - two-bit mode picks pre/post increment/decrement of the pointer
// - byte class: opcode 13..8, destination bit 7, address 6..0
// - bit class: bit index 9..7, address 6..0
// - jump and invoke carry 11-bit target in bits 10..0
// - decrement-skip takes one cycle without skip, two with skip
package iwd_pkg;
  localparam int WORD_W = 14;
  localparam int PHASES = 4;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [1:0] READ_PHASE = 2'h1;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // opcode match values and masks, masked-off bits are don't-care
  localparam logic [13:0] OP_INVOKE = 14'h2000;
  localparam logic [13:0] OP_JUMP = 14'h2800;
  localparam logic [13:0] MSK_K11 = 14'h3800;
  localparam logic [13:0] OP_SUB_EXIT = 14'h0008;
  localparam logic [13:0] OP_INT_EXIT = 14'h0009;
  localparam logic [13:0] OP_INVOKE_ACC = 14'h000a;
  localparam logic [13:0] OP_ACC_JUMP = 14'h000b;
  localparam logic [13:0] MSK_FULL = 14'h3fff;
  localparam logic [13:0] OP_EXIT_LIT = 14'h3400;
  localparam logic [13:0] MSK_HI6 = 14'h3f00;
  localparam logic [13:0] OP_REL_JUMP = 14'h3200;
  localparam logic [13:0] MSK_K9 = 14'h3e00;
  localparam logic [13:0] OP_SKIP_LOW = 14'h1800;
  localparam logic [13:0] OP_SKIP_HIGH = 14'h1c00;
  localparam logic [13:0] OP_BIT_WRITE = 14'h1000;
  localparam logic [13:0] MSK_BIT_OP = 14'h3c00;
  localparam logic [13:0] MSK_BIT_WR = 14'h3800;
  localparam logic [13:0] OP_DEC_SKIP = 14'h0b00;
  localparam logic [13:0] OP_INC_SKIP = 14'h0f00;
  localparam logic [13:0] OP_PTR_READ = 14'h0010;
  localparam logic [13:0] OP_PTR_WRITE = 14'h0018;
  localparam logic [13:0] MSK_PTR_MODE = 14'h3ff8;
  localparam logic [13:0] OP_MOVE_TO_F = 14'h0080;
  localparam logic [13:0] MSK_MOVE_TO_F = 14'h3f80;
  localparam logic [5:0] INDIRECT_PORT_HI = 6'h00;

  typedef enum logic [1:0] {
    IWD_CLS_BYTE = 2'b00,
    IWD_CLS_BIT = 2'b01,
    IWD_CLS_LITCTL = 2'b10
  } iwd_class_t;

  typedef enum logic [1:0] {
    IWD_PRE_INC = 2'b00,
    IWD_PRE_DEC = 2'b01,
    IWD_POST_INC = 2'b10,
    IWD_POST_DEC = 2'b11
  } iwd_mode_t;

  typedef struct packed {
    iwd_class_t cls;
    logic dest_file;
    logic [6:0] reg_addr;
    logic [2:0] bit_idx;
    logic ptr_num;
    iwd_mode_t upd_mode;
    logic [10:0] target;
  } iwd_fields_t;
endpackage : iwd_pkg

// >>> design/iwd_decoder.sv
// instruction word decode, read-modify-write strobes and cycle timing
`timescale 1ns/1ps
module iwd_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction word from program memory
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  // execution status from the core
  input wire logic skip_cond,
  input wire logic [1:0] ptr_in_prog_mem,
  // decoded fields and timing
  output iwd_pkg::iwd_fields_t fields_o,
  output logic [1:0] cycle_count_o,
  output logic [1:0] phase_o,
  output logic busy_o,
  output logic instr_done,
  // register file strobes
  output logic rf_rd_en,
  output logic rf_wr_en,
  output logic acc_wr_en
);
  typedef enum logic {
    IWD_IDLE = 1'b0,
    IWD_EXEC = 1'b1
  } iwd_state_t;

  iwd_state_t state_q;
  logic [1:0] phase_q;
  logic [1:0] cyc_q;
  logic [1:0] total_q;
  logic [1:0] eff_total;
  iwd_pkg::iwd_fields_t fields_q;
  iwd_pkg::iwd_fields_t fields_d;
  logic skip_q;
  logic ind_q;
  logic file_q;
  logic wr_file_q;
  logic wr_acc_q;
  logic accept;
  logic last;
  logic is_byte;
  logic is_bit;
  logic is_two;
  logic is_skip;
  logic is_ptr_op;
  logic is_bit_wr;
  logic is_move_f;
  logic ind_ptr;
  logic ind_hit;
  logic [1:0] base_cyc;

  function automatic logic op_is(input logic [13:0] w, input logic [13:0] v,
                                 input logic [13:0] m);
    op_is = (w & m) == v;
  endfunction : op_is

  // classification
  always_comb begin
    is_bit = instr_word[13:12] == 2'b01;
    is_byte = (instr_word[13:12] == 2'b00 && (instr_word[11:8] != 4'h0 || instr_word[7]))
      || (instr_word[13:12] == 2'b11
      && (instr_word[11:8] == 4'h5 || instr_word[11:8] == 4'h6 || instr_word[11:8] == 4'h7
      || instr_word[11:8] == 4'hb || instr_word[11:8] == 4'hd));
    is_two = op_is(instr_word, iwd_pkg::OP_INVOKE, iwd_pkg::MSK_K11)
      || op_is(instr_word, iwd_pkg::OP_INVOKE_ACC, iwd_pkg::MSK_FULL)
      || op_is(instr_word, iwd_pkg::OP_SUB_EXIT, iwd_pkg::MSK_FULL)
      || op_is(instr_word, iwd_pkg::OP_INT_EXIT, iwd_pkg::MSK_FULL)
      || op_is(instr_word, iwd_pkg::OP_EXIT_LIT, iwd_pkg::MSK_HI6)
      || op_is(instr_word, iwd_pkg::OP_JUMP, iwd_pkg::MSK_K11)
      || op_is(instr_word, iwd_pkg::OP_REL_JUMP, iwd_pkg::MSK_K9)
      || op_is(instr_word, iwd_pkg::OP_ACC_JUMP, iwd_pkg::MSK_FULL);
    is_skip = op_is(instr_word, iwd_pkg::OP_SKIP_LOW, iwd_pkg::MSK_BIT_OP)
      || op_is(instr_word, iwd_pkg::OP_SKIP_HIGH, iwd_pkg::MSK_BIT_OP)
      || op_is(instr_word, iwd_pkg::OP_DEC_SKIP, iwd_pkg::MSK_HI6)
      || op_is(instr_word, iwd_pkg::OP_INC_SKIP, iwd_pkg::MSK_HI6);
    is_ptr_op = op_is(instr_word, iwd_pkg::OP_PTR_READ, iwd_pkg::MSK_PTR_MODE)
      || op_is(instr_word, iwd_pkg::OP_PTR_WRITE, iwd_pkg::MSK_PTR_MODE);
    is_bit_wr = op_is(instr_word, iwd_pkg::OP_BIT_WRITE, iwd_pkg::MSK_BIT_WR);
    is_move_f = op_is(instr_word, iwd_pkg::OP_MOVE_TO_F, iwd_pkg::MSK_MOVE_TO_F);
    ind_ptr = is_ptr_op ? instr_word[2] : instr_word[0];
    ind_hit = (is_ptr_op || ((is_byte || is_bit)
      && instr_word[6:1] == iwd_pkg::INDIRECT_PORT_HI)) && ptr_in_prog_mem[ind_ptr];
    base_cyc = is_two ? iwd_pkg::CYC_TWO : iwd_pkg::CYC_ONE;
  end

  // field extraction
  always_comb begin
    fields_d = '0;
    fields_d.cls = is_bit ? iwd_pkg::IWD_CLS_BIT
      : (is_byte ? iwd_pkg::IWD_CLS_BYTE : iwd_pkg::IWD_CLS_LITCTL);
    fields_d.dest_file = is_byte ? (instr_word[7] || is_move_f) : is_bit_wr;
    fields_d.reg_addr = instr_word[6:0];
    fields_d.bit_idx = instr_word[9:7];
    fields_d.ptr_num = ind_ptr;
    fields_d.upd_mode = iwd_pkg::iwd_mode_t'(instr_word[1:0]);
    fields_d.target = instr_word[10:0];
  end

  // handshake and end of instruction
  always_comb begin
    eff_total = total_q;
    if (skip_q && skip_cond && cyc_q == 2'h0) begin
      eff_total = total_q + 2'h1;
    end
    last = state_q == IWD_EXEC && phase_q == iwd_pkg::LAST_PHASE
      && cyc_q == eff_total - 2'h1;
  end
  assign instr_ready = state_q == IWD_IDLE || last;
  assign accept = instr_valid && instr_ready;

  // state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IWD_IDLE;
    end else if (accept) begin
      state_q <= IWD_EXEC;
    end else if (last) begin
      state_q <= IWD_IDLE;
    end
  end

  // oscillator phase and instruction cycle counters
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 2'h0;
      cyc_q <= 2'h0;
    end else if (accept || state_q == IWD_IDLE) begin
      phase_q <= 2'h0;
      cyc_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == iwd_pkg::LAST_PHASE) begin
        cyc_q <= cyc_q + 2'h1;
      end
    end
  end

  // cycle cost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      total_q <= iwd_pkg::CYC_ONE;
    end else if (accept) begin
      total_q <= base_cyc + {1'b0, ind_hit};
    end else if (state_q == IWD_EXEC && phase_q == iwd_pkg::LAST_PHASE) begin
      total_q <= eff_total;
    end
  end

  // latched decode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fields_q <= '0;
      skip_q <= 1'b0;
      ind_q <= 1'b0;
      file_q <= 1'b0;
      wr_file_q <= 1'b0;
      wr_acc_q <= 1'b0;
    end else if (accept) begin
      fields_q <= fields_d;
      skip_q <= is_skip;
      ind_q <= ind_hit;
      file_q <= is_byte || is_bit;
      wr_file_q <= (is_byte || is_bit) && fields_d.dest_file;
      wr_acc_q <= is_byte && !fields_d.dest_file;
    end
  end

  // read in phase 1, store in phase 3 of the first cycle
  assign rf_rd_en = state_q == IWD_EXEC && cyc_q == 2'h0
    && phase_q == iwd_pkg::READ_PHASE && file_q;
  assign rf_wr_en = state_q == IWD_EXEC && cyc_q == 2'h0
    && phase_q == iwd_pkg::LAST_PHASE && wr_file_q;
  assign acc_wr_en = state_q == IWD_EXEC && cyc_q == 2'h0
    && phase_q == iwd_pkg::LAST_PHASE && wr_acc_q;
  assign fields_o = fields_q;
  assign cycle_count_o = total_q;
  assign phase_o = phase_q;
  assign busy_o = state_q == IWD_EXEC;
  assign instr_done = last;

  a_quarter_rate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy_o && phase_q == 2'h0 && !accept) |-> ##3 (phase_q == 2'h3))
    else $error("instruction cycle is not four clocks");
  a_single_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
    (accept && !is_two && !is_skip && !ind_hit) |=> (!instr_done)[*3] ##1 instr_done)
    else $error("plain instruction not one cycle");
  a_two_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
    (accept && is_two && !ind_hit) |=> (!instr_done)[*7] ##1 instr_done)
    else $error("branch or return not two cycles");
  a_indirect_extra: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy_o && cyc_q == 2'h0 && phase_q == 2'h3 && skip_q && skip_cond && ind_q)
    |-> !instr_done ##8 instr_done)
    else $error("indirect extra cycle missing");
  a_indirect_plain: assert property (@(posedge sys_clk) disable iff (!nrst)
    (accept && !is_two && !is_skip && ind_hit) |=> (!instr_done)[*7] ##1 instr_done)
    else $error("indirect access not two cycles");
  a_skip_taken: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy_o && cyc_q == 2'h0 && phase_q == 2'h3 && skip_q && skip_cond && !ind_q)
    |-> !instr_done ##4 instr_done)
    else $error("taken skip not two cycles");
  a_read_first: assert property (@(posedge sys_clk) disable iff (!nrst)
    rf_wr_en |-> $past(rf_rd_en, 2))
    else $error("file write without prior read");
  a_dest_excl: assert property (@(posedge sys_clk) disable iff (!nrst)
    acc_wr_en |-> (!rf_wr_en && !fields_o.dest_file && fields_o.cls == iwd_pkg::IWD_CLS_BYTE))
    else $error("destination select wrong");
  a_addr_field: assert property (@(posedge sys_clk) disable iff (!nrst)
    accept |=> (fields_o.reg_addr == $past(instr_word[6:0])
      && fields_o.bit_idx == $past(instr_word[9:7])))
    else $error("address or bit field wrong");
  a_target_field: assert property (@(posedge sys_clk) disable iff (!nrst)
    accept |=> fields_o.target == $past(instr_word[10:0]))
    else $error("jump target field wrong");
endmodule : iwd_decoder

// >>> sim/iwd_prog_model.sv
// program memory and core status model for the decoder
`timescale 1ns/1ps
module iwd_prog_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // entries {ptr, skip, word} from the bench
  input wire logic [1:0][16:0] prog,
  input wire logic [1:0] prog_len,
  input wire logic start,
  // instruction port and core status
  output logic [13:0] instr_word,
  output logic instr_valid,
  input wire logic instr_ready,
  output logic skip_cond,
  output logic [1:0] ptr_in_prog_mem
);
  logic idx_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 1'b0;
      instr_valid <= 1'b0;
      instr_word <= 14'h0000;
      skip_cond <= 1'b0;
      ptr_in_prog_mem <= 2'h0;
    end else if (start) begin
      idx_q <= 1'b0;
      instr_valid <= 1'b1;
      {ptr_in_prog_mem, instr_word} <= {prog[0][16:15], prog[0][13:0]};
    end else if (instr_valid && instr_ready) begin
      skip_cond <= prog[idx_q][14];
      idx_q <= 1'b1;
      if (!idx_q && prog_len == 2'h2) begin
        {ptr_in_prog_mem, instr_word} <= {prog[1][16:15], prog[1][13:0]};
      end else begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
        ptr_in_prog_mem <= ~ptr_in_prog_mem;
      end
    end
  end
endmodule : iwd_prog_model

// >>> sim/test_instruction_word_decode_timing.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module test_instruction_word_decode_timing;
  localparam logic [1:0] BYT = iwd_pkg::IWD_CLS_BYTE;
  localparam logic [1:0] BIT = iwd_pkg::IWD_CLS_BIT;
  localparam logic [1:0] LIT = iwd_pkg::IWD_CLS_LITCTL;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0][16:0] prog = '0;
  logic [1:0] prog_len = 2'h0;
  logic start = 1'b0;
  logic [13:0] instr_word;
  logic instr_valid;
  logic instr_ready;
  logic skip_cond;
  logic [1:0] ptr_in_prog_mem;
  iwd_pkg::iwd_fields_t fields_o;
  logic [1:0] cycle_count_o;
  logic [1:0] phase_o;
  logic busy_o;
  logic instr_done;
  logic rf_rd_en;
  logic rf_wr_en;
  logic acc_wr_en;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  iwd_prog_model i_prog (.sys_clk(sys_clk), .nrst(nrst), .prog(prog), .prog_len(prog_len),
    .start(start), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .skip_cond(skip_cond), .ptr_in_prog_mem(ptr_in_prog_mem));
  iwd_decoder i_dut (.sys_clk(sys_clk), .nrst(nrst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .skip_cond(skip_cond),
    .ptr_in_prog_mem(ptr_in_prog_mem), .fields_o(fields_o), .cycle_count_o(cycle_count_o),
    .phase_o(phase_o), .busy_o(busy_o), .instr_done(instr_done), .rf_rd_en(rf_rd_en),
    .rf_wr_en(rf_wr_en), .acc_wr_en(acc_wr_en));
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : compare
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic load(input logic [16:0] a, input logic [16:0] b, input logic [1:0] n);
    @(posedge sys_clk);
    prog <= {b, a};
    prog_len <= n;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(negedge sys_clk);
  endtask : load
  // accept to done; strb is {read, file write, acc write}
  task automatic exec(input logic [1:0] n, input logic [1:0] cls, input logic [2:0] strb);
    int k;
    int rd_at;
    int wr_at;
    int acc_at;
    k = 0;
    rd_at = 0;
    wr_at = 0;
    acc_at = 0;
    while (!(instr_valid === 1'b1 && instr_ready === 1'b1) && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
      if (rf_rd_en === 1'b1) rd_at = k;
      if (rf_wr_en === 1'b1) wr_at = k;
      if (acc_wr_en === 1'b1) acc_at = k;
    end while (instr_done !== 1'b1 && k < 20);
    compare(16'(k), 16'(4 * n));
    compare(16'(cycle_count_o), 16'(n));
    compare(16'(phase_o), 16'(iwd_pkg::LAST_PHASE));
    compare(16'(fields_o.cls), 16'(cls));
    compare(16'(rd_at), strb[2] ? 16'h0002 : 16'h0000);
    compare(16'(wr_at), strb[1] ? 16'h0004 : 16'h0000);
    compare(16'(acc_at), strb[0] ? 16'h0004 : 16'h0000);
  endtask : exec
  task automatic t_byte();
    load({3'h0, 14'h07ab}, {3'h0, 14'h072b}, 2'h2);
    exec(2'h1, BYT, 3'h6);
    compare(16'(fields_o.reg_addr), 16'h002b);
    exec(2'h1, BYT, 3'h5);
    compare(16'(fields_o.dest_file), 16'h0000);
    load({3'h0, 14'h35ab}, {3'h0, 14'h0103}, 2'h2);
    exec(2'h1, BYT, 3'h6);
    exec(2'h1, BYT, 3'h5);
    load({3'h0, 14'h0100}, 17'h0_0000, 2'h1);
    exec(2'h1, BYT, 3'h5);
  endtask : t_byte
  task automatic t_ctl();
    logic [13:0] w [8] = '{14'h27ff, 14'h2800, 14'h0008, 14'h0009, 14'h000a, 14'h000b,
      14'h34ff, 14'h33ff};
    foreach (w[i]) begin
      load({3'h0, w[i]}, 17'h0_0000, 2'h1);
      exec(2'h2, LIT, 3'h0);
      if (i == 0) compare(16'(fields_o.target), 16'h07ff);
    end
  endtask : t_ctl
  task automatic t_skip();
    logic [13:0] w [4] = '{14'h1bc5, 14'h1fc5, 14'h0bc5, 14'h0fc5};
    for (int s = 0; s < 2; s++) begin
      foreach (w[i]) begin
        load({2'h0, 1'(s), w[i]}, 17'h0_0000, 2'h1);
        exec(2'(1 + s), i < 2 ? BIT : BYT, i < 2 ? 3'h4 : 3'h6);
      end
    end
    load({3'h0, 14'h13ff}, 17'h0_0000, 2'h1);
    exec(2'h1, BIT, 3'h6);
    compare(16'(fields_o.reg_addr), 16'h007f);
    compare(16'(fields_o.bit_idx), 16'h0007);
  endtask : t_skip
  task automatic t_ind();
    load({2'h2, 1'b0, 14'h0781}, {2'h1, 1'b0, 14'h0781}, 2'h2);
    exec(2'h2, BYT, 3'h6);
    exec(2'h1, BYT, 3'h6);
    load({2'h1, 1'b1, 14'h0b80}, 17'h0_0000, 2'h1);
    exec(2'h3, BYT, 3'h6);
    for (int m = 0; m < 4; m++) begin
      load({2'h2, 1'b0, (m < 2 ? 14'h0014 : 14'h001c) | 14'(m)}, 17'h0_0000, 2'h1);
      exec(2'h2, LIT, 3'h0);
      compare(16'(fields_o.ptr_num), 16'h0001);
      compare(16'(fields_o.upd_mode), 16'(m));
    end
  endtask : t_ind
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    compare(16'(cycle_count_o), 16'h0001);
    compare(16'(busy_o), 16'h0000);
    nrst <= 1'b1;
    t_byte();
    t_ctl();
    t_skip();
    t_ind();
    print_verdict();
  end
endmodule : test_instruction_word_decode_timing
